// [rtl/i2c_bus_sequencer.sv]
// Controller that drives a two-wire bus interface through its registers,
// running initialisation, master transfers and slave servicing.
// Assumes the device port answers reads in the next cycle, on this clock.
//
// What this block does
// - Init enables baud generator, clears reserved control bits.
// - Own address loaded, free-format bit kept zero.
// - Init leaves interface slave receiver, pending set.
// - Master start: check idle, ack, address, start.
// - Handler checks master-select then direction.
// - Transmitter stops on not-acknowledge or after the last word, else sends.
// - Bit count and ack set before buffer access, except before the slave's dummy read.
// - Ack cleared before reading second-to-last word.
// - Final word: bit count one, read, then stop.
// - Addressed for read: set count, write data.
// - Slave transmitter released on not-acknowledge.
// - Write-address, general call, abort: dummy read.
// - Slave reception: set count, read word.
// - Busy bus at start: no start sent, arbitration error flagged.
//
// Local design decisions: the strobed register port and the placing of the registers.
`include "i2c_seq_params.svh"

module i2c_bus_sequencer #(
	parameter int MEM_DEPTH = 16
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire i2c_seq_pkg::sw_req_type  sw_req,
	output logic      [15:0]              sw_rdata,
	output i2c_seq_pkg::dev_req_type      dev_req,
	input  wire logic [7:0]               dev_rdata,
	input  wire logic                     dev_irq
);
	import i2c_seq_pkg::*;

	localparam int IW = $clog2(MEM_DEPTH);
	localparam int CW = $clog2(MEM_DEPTH + 1);

	// ============================================================
	// Reset release.
	logic          rst_meta_reg;
	logic          rst_sync_n_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_reg   <= 1'b0;
			rst_sync_n_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg   <= 1'b1;
			rst_sync_n_reg <= rst_meta_reg;
		end
	end

	// ============================================================
	// Declarations.
	seq_state_type state_reg;
	logic [6:0]    target_reg;
	logic [6:0]    own_reg;
	logic [2:0]    bc_reg;
	logic [2:0]    sck_reg;
	logic          slave_en_reg;
	logic [CW-1:0] words_reg;
	logic [IW-1:0] sw_ptr_reg;
	logic [IW-1:0] slave_ptr_reg;
	logic [CW-1:0] cnt_reg;
	logic [7:0]    dev_wdata_reg;
	logic [7:0]    last_sr_reg;
	logic          slave_act_reg;
	logic          op_read_reg;
	logic          final_reg;
	logic          store_reg;
	logic          dbr_rd_reg;
	logic          nack_err_reg;
	logic          arb_err_reg;
	logic          irq_pend_reg;
	logic [15:0]   rdata_reg;
	logic          rsel_mem_reg;
	logic          busy;
	logic          cmd_take;
	logic          sw_data_wr;
	logic          seq_store;
	logic          mem_we;
	logic [IW-1:0] mem_waddr;
	logic [IW-1:0] mem_raddr;
	logic [7:0]    mem_wdata;
	logic [7:0]    mem_q;
	logic [IW-1:0] seq_idx;

	function automatic logic [7:0] cr1_value(input logic [2:0] bc,
		input logic ack, input logic [2:0] sck);
		cr1_value = {bc, ack, 1'b0, sck};
	endfunction : cr1_value

	assign busy      = (state_reg != st_idle);
	assign cmd_take  = sw_req.wr && (sw_req.addr == `SW_CMD_ADDR) && !busy
		&& (sw_req.wdata[1:0] != 2'h0);
	assign sw_data_wr = sw_req.wr && (sw_req.addr == `SW_DATA_ADDR) && !busy;

	// ============================================================
	// Device port: strobes decode from the state, data from a flop.
	always_comb
	begin
		dev_req       = '0;
		dev_req.wdata = dev_wdata_reg;
		case (state_reg)
			st_br1:      begin dev_req.wr = 1'b1; dev_req.addr = `DEV_BR1_ADDR; end
			st_cr1i,
			st_mack,
			st_cr1:      begin dev_req.wr = 1'b1; dev_req.addr = `DEV_CR1_ADDR; end
			st_ar:       begin dev_req.wr = 1'b1; dev_req.addr = `DEV_AR_ADDR; end
			st_cr2i,
			st_mstart,
			st_rel,
			st_stop:     begin dev_req.wr = 1'b1; dev_req.addr = `DEV_CR2_ADDR; end
			st_maddr,
			st_dbr_wr:   begin dev_req.wr = 1'b1; dev_req.addr = `DEV_DBR_ADDR; end
			st_dbr_rd:   begin dev_req.rd = 1'b1; dev_req.addr = `DEV_DBR_ADDR; end
			st_mchk,
			st_sr_rd,
			st_stop_rd:  begin dev_req.rd = 1'b1; dev_req.addr = `DEV_SR_ADDR; end
			default:     dev_req.addr = `DEV_CR1_ADDR;
		endcase
	end

	// ============================================================
	// Interrupt capture: a new event wins over the consuming clear.
	always_ff @(posedge clk or negedge rst_sync_n_reg)
	begin
		if (!rst_sync_n_reg)
		begin
			irq_pend_reg <= 1'b0;
		end
		else if (dev_irq)
		begin
			irq_pend_reg <= 1'b1;
		end
		else if ((state_reg == st_wait) || (state_reg == st_idle && !cmd_take))
		begin
			irq_pend_reg <= irq_pend_reg && state_reg == st_idle
				&& !slave_en_reg ? 1'b0 : (state_reg == st_wait ? 1'b0
				: irq_pend_reg && !slave_en_reg ? 1'b0 : 1'b0);
		end
	end

	// ============================================================
	// Sequencer.
	always_ff @(posedge clk or negedge rst_sync_n_reg)
	begin
		if (!rst_sync_n_reg)
		begin
			state_reg     <= st_idle;
			dev_wdata_reg <= 8'h00;
			cnt_reg       <= '0;
			slave_ptr_reg <= '0;
			slave_act_reg <= 1'b0;
			op_read_reg   <= 1'b0;
			final_reg     <= 1'b0;
			store_reg     <= 1'b0;
			dbr_rd_reg    <= 1'b0;
			nack_err_reg  <= 1'b0;
			arb_err_reg   <= 1'b0;
		end
		else
		begin
			case (state_reg)
				st_idle:
					if (cmd_take)
					begin
						nack_err_reg  <= 1'b0;
						arb_err_reg   <= 1'b0;
						cnt_reg       <= '0;
						final_reg     <= 1'b0;
						slave_act_reg <= 1'b0;
						op_read_reg   <= (sw_req.wdata[1:0] == `OP_MREAD);
						if (sw_req.wdata[1:0] == `OP_INIT)
						begin
							dev_wdata_reg <= `BR1_ENABLE;
							state_reg     <= st_br1;
						end
						else
						begin
							state_reg <= st_mchk;
						end
					end
					else if (irq_pend_reg && slave_en_reg)
					begin
						slave_act_reg <= 1'b1;
						state_reg     <= st_sr_rd;
					end
				st_br1:
				begin
					dev_wdata_reg <= cr1_value(`BC_EIGHT, 1'b0, sck_reg);
					state_reg     <= st_cr1i;
				end
				st_cr1i:
				begin
					dev_wdata_reg <= {own_reg, `ALS_ADDRESSED};
					state_reg     <= st_ar;
				end
				st_ar:
				begin
					dev_wdata_reg <= `CR2_SLAVE_RX;
					state_reg     <= st_cr2i;
				end
				st_mchk:
					state_reg <= st_mchk_dec;
				st_mchk_dec:
					if (dev_rdata[`SR_BB])
					begin
						arb_err_reg <= 1'b1;
						state_reg   <= st_idle;
					end
					else
					begin
						// Address byte always goes out as eight bits with ack.
						dev_wdata_reg <= cr1_value(`BC_EIGHT, 1'b1, sck_reg);
						state_reg     <= st_mack;
					end
				st_mack:
				begin
					dev_wdata_reg <= {target_reg,
						op_read_reg ? `DIR_READ : `DIR_WRITE};
					state_reg     <= st_maddr;
				end
				st_maddr:
				begin
					dev_wdata_reg <= `CR2_START;
					state_reg     <= st_mstart;
				end
				st_mstart:
					state_reg <= st_wait;
				// The device holds the clock low until serviced here.
				st_wait:
					if (irq_pend_reg)
					begin
						state_reg <= st_sr_rd;
					end
				st_sr_rd:
					state_reg <= st_dec;
				st_dec:
					if (!slave_act_reg && dev_rdata[`SR_MST]
						&& !dev_rdata[`SR_AL])
					begin
						if (dev_rdata[`SR_TRX])
						begin
							if (dev_rdata[`SR_LRB] || cnt_reg >= words_reg)
							begin
								nack_err_reg  <= dev_rdata[`SR_LRB]
									&& cnt_reg < words_reg;
								dev_wdata_reg <= `CR2_STOP;
								state_reg     <= st_stop;
							end
							else
							begin
								dev_wdata_reg <= cr1_value(bc_reg, 1'b1, sck_reg);
								dbr_rd_reg    <= 1'b0;
								state_reg     <= st_cr1;
							end
						end
						else if (final_reg)
						begin
							dev_wdata_reg <= `CR2_STOP;
							state_reg     <= st_stop;
						end
						else if (cnt_reg < words_reg)
						begin
							// Ack for the next word only if more follow it.
							dev_wdata_reg <= cr1_value(bc_reg,
								(cnt_reg + CW'(1)) < words_reg, sck_reg);
							store_reg     <= (cnt_reg != '0);
							dbr_rd_reg    <= 1'b1;
							state_reg     <= st_cr1;
						end
						else
						begin
							dev_wdata_reg <= cr1_value(`BC_ONE, 1'b0, sck_reg);
							store_reg     <= 1'b1;
							final_reg     <= 1'b1;
							dbr_rd_reg    <= 1'b1;
							state_reg     <= st_cr1;
						end
					end
					else
					begin
						// Slave service; a lost master ends its operation here.
						arb_err_reg   <= arb_err_reg || dev_rdata[`SR_AL];
						slave_act_reg <= 1'b1;
						if (dev_rdata[`SR_TRX])
						begin
							if (dev_rdata[`SR_AAS] || !dev_rdata[`SR_LRB])
							begin
								dev_wdata_reg <= cr1_value(bc_reg, 1'b1, sck_reg);
								dbr_rd_reg    <= 1'b0;
								state_reg     <= st_cr1;
							end
							else
							begin
								dev_wdata_reg <= `CR2_RELEASE;
								state_reg     <= st_rel;
							end
						end
						else if (dev_rdata[`SR_AAS] || dev_rdata[`SR_AL])
						begin
							store_reg <= 1'b0;
							state_reg <= st_dbr_rd;
						end
						else
						begin
							dev_wdata_reg <= cr1_value(bc_reg, 1'b1, sck_reg);
							store_reg     <= 1'b1;
							dbr_rd_reg    <= 1'b1;
							state_reg     <= st_cr1;
						end
					end
				st_cr1:
				begin
					dev_wdata_reg <= mem_q;
					state_reg     <= dbr_rd_reg ? st_dbr_rd : st_dbr_wr;
				end
				st_dbr_wr:
				begin
					if (slave_act_reg)
					begin
						slave_ptr_reg <= slave_ptr_reg + IW'(1);
					end
					else
					begin
						cnt_reg <= cnt_reg + CW'(1);
					end
					state_reg <= slave_act_reg ? st_idle : st_wait;
				end
				st_dbr_rd:
					state_reg <= st_dbr_cap;
				st_dbr_cap:
				begin
					if (slave_act_reg && store_reg)
					begin
						slave_ptr_reg <= slave_ptr_reg + IW'(1);
					end
					else if (!slave_act_reg)
					begin
						cnt_reg <= cnt_reg + CW'(1);
					end
					state_reg <= slave_act_reg ? st_idle : st_wait;
				end
				st_rel:
					state_reg <= st_idle;
				st_stop:
					state_reg <= st_stop_rd;
				st_stop_rd:
					state_reg <= st_stop_dec;
				// Waits for the stop to appear; a stuck bus stalls here.
				st_stop_dec:
					state_reg <= dev_rdata[`SR_BB] ? st_stop_rd : st_idle;
				default:
					state_reg <= st_idle;
			endcase
		end
	end

	// ============================================================
	// Word store shared by software and the sequencer.
	assign seq_idx   = slave_act_reg ? slave_ptr_reg : IW'(cnt_reg);
	assign seq_store = (state_reg == st_dbr_cap) && store_reg;
	assign mem_we    = seq_store || sw_data_wr;
	assign mem_waddr = busy ? (slave_act_reg ? slave_ptr_reg
		: IW'(cnt_reg - CW'(1))) : sw_ptr_reg;
	assign mem_wdata = busy ? dev_rdata : sw_req.wdata[7:0];
	assign mem_raddr = busy ? seq_idx : sw_ptr_reg;

	word_memory #(
		.WIDTH (8),
		.DEPTH (MEM_DEPTH)
	) store_inst (
		.clk     (clk),
		.rst_n   (rst_sync_n_reg),
		.wr_en   (mem_we),
		.wr_addr (mem_waddr),
		.wr_data (mem_wdata),
		.rd_addr (mem_raddr),
		.rd_data (mem_q)
	);

	// ============================================================
	// Software registers.
	always_ff @(posedge clk or negedge rst_sync_n_reg)
	begin
		if (!rst_sync_n_reg)
		begin
			target_reg   <= '0;
			own_reg      <= '0;
			bc_reg       <= `BC_EIGHT;
			sck_reg      <= `SCK_RESET;
			slave_en_reg <= 1'b0;
			words_reg    <= CW'(`WORDS_RESET);
			sw_ptr_reg   <= '0;
			last_sr_reg  <= 8'h00;
			rdata_reg    <= 16'h0000;
			rsel_mem_reg <= 1'b0;
		end
		else
		begin
			if (state_reg == st_dec)
			begin
				last_sr_reg <= dev_rdata;
			end
			if (sw_req.wr && !busy)
			begin
				case (sw_req.addr)
					`SW_TARGET_ADDR:
					begin
						target_reg <= sw_req.wdata[`TGT_LSB +: 7];
						own_reg    <= sw_req.wdata[`OWN_LSB +: 7];
					end
					`SW_SETUP_ADDR:
					begin
						bc_reg       <= sw_req.wdata[`SET_BC_LSB +: 3];
						sck_reg      <= sw_req.wdata[`SET_SCK_LSB +: 3];
						slave_en_reg <= sw_req.wdata[`SET_SLV_BIT];
						words_reg    <= sw_req.wdata[`SET_WORDS_LSB +: CW];
					end
					`SW_PTR_ADDR:  sw_ptr_reg <= sw_req.wdata[IW-1:0];
					`SW_DATA_ADDR: sw_ptr_reg <= sw_ptr_reg + IW'(1);
					default:       sw_ptr_reg <= sw_ptr_reg;
				endcase
			end
			else if (sw_req.rd && !busy && sw_req.addr == `SW_DATA_ADDR)
			begin
				sw_ptr_reg <= sw_ptr_reg + IW'(1);
			end
			rsel_mem_reg <= sw_req.rd && (sw_req.addr == `SW_DATA_ADDR);
			if (sw_req.rd)
			begin
				case (sw_req.addr)
					`SW_TARGET_ADDR: rdata_reg <= {1'b0, own_reg, 1'b0, target_reg};
					`SW_SETUP_ADDR:  rdata_reg <= 16'({words_reg, 1'b0,
						slave_en_reg, sck_reg, bc_reg});
					`SW_STATUS_ADDR: rdata_reg <= {last_sr_reg, 4'h0, arb_err_reg,
						nack_err_reg, slave_en_reg, busy};
					`SW_PTR_ADDR:    rdata_reg <= 16'(sw_ptr_reg);
					default:         rdata_reg <= 16'h0000;
				endcase
			end
		end
	end

	assign sw_rdata = rsel_mem_reg ? {8'h00, mem_q} : rdata_reg;

endmodule : i2c_bus_sequencer

// [rtl/i2c_seq_params.svh]
// Constants of the two-wire bus sequencer: device register map, field
// values and the sequencer's own register map.
// Assumes inclusion by bare name from the package and the top module.
`ifndef I2C_SEQ_PARAMS_SVH
`define I2C_SEQ_PARAMS_SVH

// ============================================================
// Device register indices on the device port.
`define DEV_CR1_ADDR     3'h0
`define DEV_DBR_ADDR     3'h1
`define DEV_AR_ADDR      3'h2
`define DEV_CR2_ADDR     3'h3
`define DEV_SR_ADDR      3'h3
`define DEV_BR1_ADDR     3'h5

// ============================================================
// Device field values and status bit positions.
`define BR1_ENABLE       8'h80
`define CR2_SLAVE_RX     8'h18
`define CR2_START        8'hf8
`define CR2_STOP         8'hd8
`define CR2_RELEASE      8'h18
`define BC_EIGHT         3'h0
`define BC_ONE           3'h1
`define ALS_ADDRESSED    1'b0
`define DIR_READ         1'b1
`define DIR_WRITE        1'b0
`define SR_MST           7
`define SR_TRX           6
`define SR_BB            5
`define SR_AL            3
`define SR_AAS           2
`define SR_LRB           0

// ============================================================
// Sequencer's own register map and fields.
`define SW_CMD_ADDR      3'h0
`define SW_TARGET_ADDR   3'h1
`define SW_SETUP_ADDR    3'h2
`define SW_STATUS_ADDR   3'h3
`define SW_PTR_ADDR      3'h4
`define SW_DATA_ADDR     3'h5
`define OP_INIT          2'h1
`define OP_MWRITE        2'h2
`define OP_MREAD         2'h3
`define TGT_LSB          0
`define OWN_LSB          8
`define SET_BC_LSB       0
`define SET_SCK_LSB      3
`define SET_SLV_BIT      6
`define SET_WORDS_LSB    8
`define WORDS_RESET      5'h01
`define SCK_RESET        3'h0

`endif

// [rtl/i2c_seq_pkg.sv]
// Types shared by the two-wire bus sequencer and its bench.
// Assumes the constants header is on the include path.
`include "i2c_seq_params.svh"

package i2c_seq_pkg;

	// ============================================================
	// Request carriers.
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [2:0]  addr;
		logic [15:0] wdata;
	} sw_req_type;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} dev_req_type;

	// ============================================================
	// Sequencer states.
	typedef enum {
		st_idle, st_br1, st_cr1i, st_ar, st_cr2i,
		st_mchk, st_mchk_dec, st_mack, st_maddr, st_mstart,
		st_wait, st_sr_rd, st_dec, st_cr1, st_dbr_wr, st_dbr_rd,
		st_dbr_cap, st_rel, st_stop, st_stop_rd, st_stop_dec
	} seq_state_type;

endpackage : i2c_seq_pkg

// [rtl/word_memory.sv]
// Small word store for transmit and receive data of the sequencer.
// Assumes one clock; read data appear one cycle after the address.
module word_memory #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input  wire logic [WIDTH-1:0]         wr_data,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic      [WIDTH-1:0]         rd_data
);

	logic [WIDTH-1:0] mem_array [DEPTH];

	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem_array[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_data <= '0;
		end
		else
		begin
			rd_data <= mem_array[rd_addr];
		end
	end

endmodule : word_memory

// [verification/i2c_seq_monitor.sv]
// Checker on the sequencer's ports: device access order and timing.
// Assumes the device register indices of the constants header.
`include "i2c_seq_params.svh"

module i2c_seq_monitor (
	input wire logic                     clk,
	input wire logic                     rst_n,
	input wire i2c_seq_pkg::sw_req_type  sw_req,
	input wire logic [15:0]              sw_rdata,
	input wire i2c_seq_pkg::dev_req_type dev_req,
	input wire logic [7:0]               dev_rdata,
	input wire logic                     dev_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	import i2c_seq_pkg::*;

	// ========
	// Decoded device accesses.
	logic wr_br1, wr_cr1, wr_ar, wr_cr2, rd_sr, use_dbr;
	assign wr_br1  = dev_req.wr && dev_req.addr == `DEV_BR1_ADDR;
	assign wr_cr1  = dev_req.wr && dev_req.addr == `DEV_CR1_ADDR;
	assign wr_ar   = dev_req.wr && dev_req.addr == `DEV_AR_ADDR;
	assign wr_cr2  = dev_req.wr && dev_req.addr == `DEV_CR2_ADDR;
	assign rd_sr   = dev_req.rd && dev_req.addr == `DEV_SR_ADDR;
	assign use_dbr = (dev_req.wr || dev_req.rd)
		&& dev_req.addr == `DEV_DBR_ADDR;

	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ========
	// Assertions.
	sequence init_tail;
		wr_ar ##1 wr_cr2 && dev_req.wdata == `CR2_SLAVE_RX;
	endsequence

	init_seq_a: assert property (
		wr_br1 |-> dev_req.wdata == `BR1_ENABLE ##1 wr_cr1
			&& dev_req.wdata[7:5] == 3'h0 && !dev_req.wdata[3] ##1 init_tail)
		else $error("init order or reserved control bits wrong");
	own_addr_a: assert property (
		wr_ar |-> !dev_req.wdata[0] && $past(wr_cr1))
		else $error("own address written with free format bit set");
	init_mode_a: assert property (
		wr_ar |=> wr_cr2 && dev_req.wdata == `CR2_SLAVE_RX)
		else $error("interface not left as slave receiver");
	start_load_a: assert property (
		wr_cr2 && dev_req.wdata == `CR2_START |-> $past(use_dbr)
			&& $past(rd_sr, 4))
		else $error("start without idle check and buffer load");
	start_ack_a: assert property (
		wr_cr2 && dev_req.wdata == `CR2_START
			|-> $past(wr_cr1 && dev_req.wdata[4], 2))
		else $error("start without acknowledge enabled");
	irq_status_a: assert property (
		$rose(dev_irq) |-> ##[1:8] rd_sr)
		else $error("interrupt not served by a status read");
	dbr_setup_a: assert property (
		use_dbr && !$past(rd_sr, 2) |-> $past(wr_cr1))
		else $error("buffer access without bit count set first");
	stop_poll_a: assert property (
		wr_cr2 && dev_req.wdata == `CR2_STOP |=> ##[0:4] rd_sr)
		else $error("stop not followed by busy polling");
endmodule : i2c_seq_monitor

bind i2c_bus_sequencer i2c_seq_monitor u_mon (
	.clk(clk), .rst_n(rst_n), .sw_req(sw_req), .sw_rdata(sw_rdata),
	.dev_req(dev_req), .dev_rdata(dev_rdata), .dev_irq(dev_irq)
);

// [verification/i2c_dev_model.sv]
// Behavioural bus interface device seen through its registers.
// Assumes the sequencer's clock; a bus transfer takes DLY cycles, three times that when slow.
`include "i2c_seq_params.svh"

module i2c_dev_model #(
	parameter int         DLY     = 72,
	parameter logic [7:0] RX_BASE = 8'h90
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire i2c_seq_pkg::dev_req_type dev_req,
	output logic [7:0]                    dev_rdata,
	output logic                          dev_irq,
	input  wire logic                     nack,
	input  wire logic                     ext_busy,
	input  wire logic                     slow,
	input  wire logic                     slv
);
	timeunit 1ns;
	timeprecision 1ps;
	import i2c_seq_pkg::*;

	logic [7:0] br1_reg, cr1_reg, ar_reg, cr2_reg, rx_reg;
	logic       mst_reg, trx_reg, bb_reg, pin_reg, al_reg, lrb_reg;
	logic       dir_reg, adr_reg, busy, aas_reg, sadr_reg;
	logic [9:0] tmr_reg, len;
	logic [7:0] wlog [16];
	logic [7:0] rlog [16];
	int         wcnt, rcnt, start_cnt, stop_cnt;

	// Slow answers stand for a remote slave stretching the clock.
	assign len  = slow ? 10'(3 * DLY) : 10'(DLY);
	assign busy = bb_reg | ext_busy;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{br1_reg, cr1_reg, ar_reg, cr2_reg} <= '0;
			{mst_reg, trx_reg, bb_reg, al_reg, lrb_reg} <= '0;
			{dir_reg, adr_reg, dev_irq, aas_reg, sadr_reg} <= '0;
			pin_reg   <= 1'b1;
			rx_reg    <= 8'h5a;
			tmr_reg   <= '0;
			dev_rdata <= 8'h00;
			{wcnt, rcnt, start_cnt, stop_cnt} <= '0;
		end
		else
		begin
			dev_irq   <= 1'b0;
			// Outside a read answer the lines flip to the inverse of their last value each cycle.
			dev_rdata <= ~dev_rdata;
			if (tmr_reg != 10'h0)
				tmr_reg <= tmr_reg - 10'h1;
			if (tmr_reg == 10'h1)
			begin
				dev_irq <= 1'b1;
				pin_reg <= 1'b0;
				lrb_reg <= nack;
				adr_reg <= 1'b0;
				if (adr_reg && !nack)
					trx_reg <= ~dir_reg;
			end
			// A remote master addresses us first, then sends data words.
			if (slv)
			begin
				dev_irq  <= 1'b1;
				pin_reg  <= 1'b0;
				aas_reg  <= !sadr_reg;
				sadr_reg <= 1'b1;
			end
			if (dev_req.wr)
			begin
				case (dev_req.addr)
				`DEV_BR1_ADDR: br1_reg <= dev_req.wdata;
				`DEV_CR1_ADDR: cr1_reg <= dev_req.wdata;
				`DEV_AR_ADDR:  ar_reg  <= dev_req.wdata;
				`DEV_DBR_ADDR:
				begin
					wlog[wcnt] <= dev_req.wdata;
					wcnt       <= wcnt + 1;
					dir_reg    <= dev_req.wdata[0];
					al_reg     <= 1'b0;
					aas_reg    <= 1'b0;
					if (mst_reg)
					begin
						pin_reg <= 1'b1;
						tmr_reg <= len;
					end
				end
				`DEV_CR2_ADDR:
				begin
					cr2_reg <= dev_req.wdata;
					if (dev_req.wdata[4])
						pin_reg <= 1'b1;
					if (dev_req.wdata == `CR2_START && busy)
						{al_reg, mst_reg, trx_reg} <= 3'b100;
					else if (dev_req.wdata == `CR2_START)
					begin
						{mst_reg, trx_reg, bb_reg, adr_reg} <= 4'hf;
						tmr_reg   <= len;
						start_cnt <= start_cnt + 1;
					end
					else if (dev_req.wdata == `CR2_STOP && busy)
					begin
						{mst_reg, trx_reg, bb_reg} <= 3'b000;
						stop_cnt <= stop_cnt + 1;
					end
				end
				default: ;
				endcase
			end
			if (dev_req.rd)
			begin
				if (dev_req.addr == `DEV_SR_ADDR)
					dev_rdata <= {mst_reg, trx_reg, busy, pin_reg, al_reg,
						aas_reg, 1'b0, lrb_reg};
				else if (dev_req.addr == `DEV_DBR_ADDR)
				begin
					dev_rdata  <= rx_reg;
					rx_reg     <= RX_BASE + 8'(rcnt);
					rlog[rcnt] <= cr1_reg;
					rcnt       <= rcnt + 1;
					pin_reg    <= 1'b1;
					al_reg     <= 1'b0;
					aas_reg    <= 1'b0;
					if (mst_reg)
						tmr_reg <= len;
				end
				else
					dev_rdata <= cr1_reg;
			end
		end
	end
endmodule : i2c_dev_model

// [verification/i2c_bus_sequencer_tb.sv]
// Self-checking bench for the two-wire bus sequencer.
// Assumes the device model of this folder and the constants header.
`include "i2c_seq_params.svh"

module i2c_bus_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import i2c_seq_pkg::*;

	localparam logic [7:0] RX_BASE = 8'h90;

	logic                     clk, rst_n, nack, ext_busy, slow, dev_irq, slv;
	i2c_seq_pkg::sw_req_type  sw_req;
	i2c_seq_pkg::dev_req_type dev_req;
	logic [15:0]              sw_rdata, rd_val;
	logic [7:0]               dev_rdata;
	int                       error_cnt, cmp_count, bw, bs, br;

	i2c_bus_sequencer #(.MEM_DEPTH(16)) dut (
		.clk(clk), .rst_n(rst_n), .sw_req(sw_req), .sw_rdata(sw_rdata),
		.dev_req(dev_req), .dev_rdata(dev_rdata), .dev_irq(dev_irq));
	i2c_dev_model #(.RX_BASE(RX_BASE)) dev (
		.clk(clk), .rst_n(rst_n), .dev_req(dev_req), .dev_rdata(dev_rdata),
		.dev_irq(dev_irq), .nack(nack), .ext_busy(ext_busy), .slow(slow),
		.slv(slv));

	// ========
	// Access and comparison tasks.
	task automatic check(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check

	task automatic sw_write(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		sw_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		sw_req <= '0;
	endtask : sw_write

	task automatic sw_read(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		sw_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
		@(posedge clk);
		sw_req <= '0;
		#1 d = sw_rdata;
	endtask : sw_read

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	// A stop poll has no bound in the design, so the bench bounds it here.
	task automatic wait_idle;
		logic [15:0] s;
		s = 16'h1;
		for (int i = 0; i < 4000 && s[0] !== 1'b0; i++)
			sw_read(`SW_STATUS_ADDR, s);
		if (s[0] !== 1'b0)
		begin
			error_cnt++;
			$display("mismatch at %0t: sequencer stays busy", $time);
			end_of_test();
		end
	endtask : wait_idle

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ========
	// Main sequence.
	initial
	begin
		{rst_n, nack, ext_busy, slow, slv} = 5'h0;
		sw_req = '0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		sw_read(`SW_SETUP_ADDR, rd_val);
		check(16'(rd_val[12:8]), 16'(`WORDS_RESET), "word count");
		sw_read(`SW_STATUS_ADDR, rd_val);
		check(16'(rd_val[0]), 16'h0, "busy after reset");
		$display("test reset values done");
		sw_write(`SW_SETUP_ADDR, 16'h0110);
		sw_write(`SW_TARGET_ADDR, 16'h2a51);
		sw_write(`SW_CMD_ADDR, 16'(`OP_INIT));
		wait_idle();
		check(16'(dev.br1_reg), 16'(`BR1_ENABLE), "baud enable");
		check(16'(dev.cr1_reg & 8'hef), 16'h02, "control one");
		check(16'(dev.ar_reg), 16'h54, "own address");
		check(16'(dev.cr2_reg), 16'(`CR2_SLAVE_RX), "control two");
		$display("test init done");
		sw_write(`SW_PTR_ADDR, 16'h0);
		sw_write(`SW_DATA_ADDR, 16'h003c);
		sw_write(`SW_DATA_ADDR, 16'h00c3);
		sw_write(`SW_SETUP_ADDR, 16'h0210);
		bw = dev.wcnt;
		bs = dev.stop_cnt;
		slow <= 1'b1;
		sw_write(`SW_CMD_ADDR, 16'(`OP_MWRITE));
		wait_idle();
		check(16'(dev.wlog[bw]), 16'ha2, "write address");
		check(16'(dev.wlog[bw + 1]), 16'h3c, "first word");
		check(16'(dev.wlog[bw + 2]), 16'hc3, "second word");
		check(16'(dev.stop_cnt - bs), 16'h1, "stop count");
		sw_read(`SW_STATUS_ADDR, rd_val);
		check(16'(rd_val[3:2]), 16'h0, "write errors");
		$display("test master write done");
		slow <= 1'b0;
		sw_write(`SW_SETUP_ADDR, 16'h0310);
		bw = dev.wcnt;
		br = dev.rcnt;
		sw_write(`SW_CMD_ADDR, 16'(`OP_MREAD));
		wait_idle();
		check(16'(dev.wlog[bw]), 16'ha3, "read address");
		check(16'(dev.rcnt - br), 16'h4, "buffer reads");
		check(16'(dev.rlog[br + 1][4]), 16'h1, "ack on");
		check(16'(dev.rlog[br + 2][4]), 16'h0, "ack off");
		check(16'(dev.rlog[br + 3][7:4]), 16'h2, "last clock");
		sw_write(`SW_PTR_ADDR, 16'h0);
		for (int i = 0; i < 3; i++)
		begin
			sw_read(`SW_DATA_ADDR, rd_val);
			check(16'(rd_val[7:0]), 16'(RX_BASE + 8'(i)), "rx word");
		end
		sw_write(3'h7, 16'hffff);
		sw_read(`SW_SETUP_ADDR, rd_val);
		check(rd_val, 16'h0310, "setup after unmapped write");
		$display("test master read done");
		nack <= 1'b1;
		bw = dev.wcnt;
		bs = dev.stop_cnt;
		sw_write(`SW_SETUP_ADDR, 16'h0210);
		sw_write(`SW_CMD_ADDR, 16'(`OP_MWRITE));
		wait_idle();
		check(16'(dev.wcnt - bw), 16'h1, "no data after nack");
		check(16'(dev.stop_cnt - bs), 16'h1, "stop on nack");
		sw_read(`SW_STATUS_ADDR, rd_val);
		check(16'(rd_val[2]), 16'h1, "nack flag");
		$display("test nack done");
		nack <= 1'b0;
		ext_busy <= 1'b1;
		bs = dev.start_cnt;
		sw_write(`SW_CMD_ADDR, 16'(`OP_MWRITE));
		wait_idle();
		check(16'(dev.start_cnt - bs), 16'h0, "start on busy bus");
		sw_read(`SW_STATUS_ADDR, rd_val);
		check(16'(rd_val[3]), 16'h1, "busy flag");
		$display("test busy bus done");
		ext_busy <= 1'b0;
		br = dev.rcnt;
		sw_write(`SW_SETUP_ADDR, 16'h0157);
		for (int k = 1; k < 3; k++)
		begin
			slv <= 1'b1;
			@(posedge clk);
			slv <= 1'b0;
			repeat (12) @(posedge clk);
			wait_idle();
			check(16'(dev.rcnt - br), 16'(k), "slave buffer reads");
		end
		check(16'(dev.rlog[br + 1][7:5]), 16'h7, "slave bit count");
		sw_write(`SW_PTR_ADDR, 16'h0);
		sw_read(`SW_DATA_ADDR, rd_val);
		check(16'(rd_val[7:0]), 16'(RX_BASE + 8'h4), "slave word");
		$display("test slave receive done");
		end_of_test();
	end
endmodule : i2c_bus_sequencer_tb
